// >>> design/fcs_pkg.sv
// constants and carrier types for the flash controller status flags
package fcs_pkg;

    // register byte offsets on the apb bus
    localparam int              ADDR_W       = 8;
    localparam logic [ADDR_W-1:0] OFF_CMD      = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_WDATA    = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_IRQ_FLAG = 8'h40;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h44;

    // status register layout
    localparam int STATUS_W   = 7;
    localparam int BIT_BUSY   = 0;
    localparam int BIT_LOCKED = 1;
    localparam int BIT_INVADR = 2;
    localparam int BIT_WREADY = 3;
    localparam int BIT_TMOUT  = 4;
    localparam int BIT_ABORT  = 5;
    localparam int BIT_PCRUN  = 6;

    // command register layout (write only, reads as zero)
    localparam int CMD_ERASE_PAGE   = 0;
    localparam int CMD_WRITE_TRIG   = 1;
    localparam int CMD_SINGLE_WRITE = 2;
    localparam int CMD_PERF_START   = 3;

    // interrupt flag and mask layout
    localparam int IRQ_W       = 5;
    localparam int IRQ_DONE    = 0;
    localparam int IRQ_TMOUT   = 1;
    localparam int IRQ_ABORT   = 2;
    localparam int IRQ_LOCKED  = 3;
    localparam int IRQ_INVADR  = 4;

    // reset values
    localparam logic [31:0]      WDATA_RST = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] IRQ_RST   = 5'h00;

    // timing
    localparam int CLK_PERIOD_NS = 25;

    // sequencer operation in progress
    typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_WRITE} fcs_op_e;

    // apb request fields that travel together
    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              pwrite;
        logic [31:0]       pwdata;
    } fcs_apb_req_s;

    // events reported by the write and erase sequencer
    typedef struct packed {
        logic word_taken;
        logic op_done;
        logic erase_interrupted;
        logic access_denied;
        logic addr_invalid;
        logic perf_overflow;
    } fcs_seq_evt_s;

    // commands and handshakes sent to the sequencer
    typedef struct packed {
        logic erase_page;
        logic write_trigger;
        logic single_write;
        logic release_flash;
        logic word_valid;
        logic perf_run;
    } fcs_seq_cmd_s;

endpackage

// >>> design/fcs_status_flags.sv
// status flags, command gate and write-word handshake of the flash controller
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps

// Summary of operation
// - counters-running set while running, cleared on overflow
// - erase-aborted set when interrupt cuts erase
// - word timeout sets flag, ends write, releases flash
// - any erase or write command clears timeout
// - write-data-ready resets high, rises taken, drops written
// - invalid address load sets invalid-address flag
// - access-locked set when operation forbidden by constraints
// - busy during operation; new erase and write commands ignored then
module fcs_status_flags #(
    parameter int WORD_TIMEOUT_NS = 10000
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire fcs_pkg::fcs_apb_req_s apb_req,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    input  wire fcs_pkg::fcs_seq_evt_s seq_evt,
    output fcs_pkg::fcs_seq_cmd_s      seq_cmd,
    output logic [31:0]                flash_write_data_reg,
    output logic                       irq
);
    import fcs_pkg::*;

    // a timeout is reached after at least this many cycles of waiting
    localparam int TO_CYC = (WORD_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TO_W   = $clog2(TO_CYC + 1);
    localparam logic [TO_W-1:0] TO_LAST = TO_W'(TO_CYC - 1);
    localparam logic [TO_W-1:0] TO_ZERO = '0;

    fcs_op_e              op;
    fcs_op_e              next_op;
    logic                 locked;
    logic                 invalid_address_flag;
    logic                 write_data_ready_flag;
    logic                 write_word_timeout_flag;
    logic                 erase_aborted_flag;
    logic                 perf_counters_running;
    logic [TO_W-1:0]      to_cnt;
    logic [IRQ_W-1:0]     irq_flag;
    logic [IRQ_W-1:0]     irq_mask;
    logic [IRQ_W-1:0]     next_irq_flag;
    logic [IRQ_W-1:0]     next_irq_mask;
    logic [IRQ_W-1:0]     irq_evt;
    logic [STATUS_W-1:0]  flash_controller_status;

    // apb phase decode
    wire setup_ph  = psel & ~penable;
    wire access_ph = psel & penable & pready;
    wire wr_acc    = access_ph & apb_req.pwrite;

    // address decode
    wire hit_cmd    = apb_req.paddr == OFF_CMD;
    wire hit_wdata  = apb_req.paddr == OFF_WDATA;
    wire hit_status = apb_req.paddr == OFF_STATUS;
    wire hit_iflag  = apb_req.paddr == OFF_IRQ_FLAG;
    wire hit_imask  = apb_req.paddr == OFF_IRQ_MASK;
    wire mapped     = hit_cmd | hit_wdata | hit_status | hit_iflag | hit_imask;

    // command decode; status writes have no path into any flag
    wire cmd_wr      = wr_acc & hit_cmd;
    wire cmd_erase   = cmd_wr & apb_req.pwdata[CMD_ERASE_PAGE];
    wire cmd_wtrig   = cmd_wr & apb_req.pwdata[CMD_WRITE_TRIG];
    wire cmd_single  = cmd_wr & apb_req.pwdata[CMD_SINGLE_WRITE];
    wire cmd_any     = cmd_erase | cmd_wtrig | cmd_single;
    wire perf_start  = cmd_wr & apb_req.pwdata[CMD_PERF_START];
    wire busy        = op != OP_IDLE;
    wire accept      = cmd_any & ~busy;

    // write data only lands while the ready flag is up
    wire wdata_wr = wr_acc & hit_wdata & write_data_ready_flag;

    // timeout watch while a write waits on software for the next word
    wire to_run      = (op == OP_WRITE) & write_data_ready_flag;
    wire timeout_hit = to_run & (to_cnt == TO_LAST);
    wire abort_hit   = seq_evt.erase_interrupted & (op == OP_ERASE);
    wire locked_hit  = seq_evt.access_denied & busy;
    wire done_hit    = seq_evt.op_done & busy;
    wire end_op      = done_hit | abort_hit | locked_hit | timeout_hit;

    // next operation state
    always_comb begin
        next_op = op;
        case (op)
            OP_IDLE: begin
                if (accept) begin
                    next_op = cmd_erase ? OP_ERASE : OP_WRITE;
                end
            end
            OP_ERASE, OP_WRITE: begin
                if (end_op) begin
                    next_op = OP_IDLE;
                end
            end
            default: begin
                next_op = OP_IDLE;
            end
        endcase
    end

    // operation state register; busy is any state but idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op <= OP_IDLE;
        end else begin
            op <= next_op;
        end
    end

    // word timeout counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            to_cnt <= TO_ZERO;
        end else if (to_run && !timeout_hit) begin
            to_cnt <= to_cnt + TO_W'(1);
        end else begin
            to_cnt <= TO_ZERO;
        end
    end

    // flags set by the sequencer or the word timeout, set winning over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_word_timeout_flag <= 1'b0;
            erase_aborted_flag      <= 1'b0;
            locked                  <= 1'b0;
            invalid_address_flag                 <= 1'b0;
        end else begin
            write_word_timeout_flag <= timeout_hit | (write_word_timeout_flag & ~cmd_any);
            erase_aborted_flag      <= abort_hit | (erase_aborted_flag & ~accept);
            locked                  <= locked_hit | (locked & ~accept);
            invalid_address_flag                 <= seq_evt.addr_invalid | (invalid_address_flag & ~accept);
        end
    end

    // write data handshake flag, high out of reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_data_ready_flag <= 1'b1;
        end else begin
            write_data_ready_flag <= seq_evt.word_taken | (write_data_ready_flag & ~wdata_wr);
        end
    end

    // performance counters running flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            perf_counters_running <= 1'b0;
        end else begin
            perf_counters_running <= perf_start | (perf_counters_running & ~seq_evt.perf_overflow);
        end
    end

    // write data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_write_data_reg <= WDATA_RST;
        end else if (wdata_wr) begin
            flash_write_data_reg <= apb_req.pwdata;
        end
    end

    // status word as software sees it
    assign flash_controller_status[BIT_BUSY]   = busy;
    assign flash_controller_status[BIT_LOCKED] = locked;
    assign flash_controller_status[BIT_INVADR] = invalid_address_flag;
    assign flash_controller_status[BIT_WREADY] = write_data_ready_flag;
    assign flash_controller_status[BIT_TMOUT]  = write_word_timeout_flag;
    assign flash_controller_status[BIT_ABORT]  = erase_aborted_flag;
    assign flash_controller_status[BIT_PCRUN]  = perf_counters_running;

    // interrupt events, one per status event
    assign irq_evt[IRQ_DONE]   = done_hit;
    assign irq_evt[IRQ_TMOUT]  = timeout_hit;
    assign irq_evt[IRQ_ABORT]  = abort_hit;
    assign irq_evt[IRQ_LOCKED] = locked_hit;
    assign irq_evt[IRQ_INVADR] = seq_evt.addr_invalid;

    // write one to clear; a new event wins over the clear
    wire [IRQ_W-1:0] irq_clr = (wr_acc & hit_iflag) ? apb_req.pwdata[IRQ_W-1:0] : IRQ_RST;
    assign next_irq_flag = irq_evt | (irq_flag & ~irq_clr);
    assign next_irq_mask = (wr_acc & hit_imask) ? apb_req.pwdata[IRQ_W-1:0] : irq_mask;

    // interrupt registers and level output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flag <= IRQ_RST;
            irq_mask <= IRQ_RST;
            irq      <= 1'b0;
        end else begin
            irq_flag <= next_irq_flag;
            irq_mask <= next_irq_mask;
            irq      <= |(next_irq_flag & next_irq_mask);
        end
    end

    // read mux; unused upper bits read as zero
    wire [31:0] rd_data = hit_status ? {{(32-STATUS_W){1'b0}}, flash_controller_status} :
                          hit_wdata  ? flash_write_data_reg :
                          hit_iflag  ? {{(32-IRQ_W){1'b0}}, irq_flag} :
                          hit_imask  ? {{(32-IRQ_W){1'b0}}, irq_mask} : 32'h0000_0000;

    // apb answer: one wait-free access phase after every setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_ph;
            prdata  <= (setup_ph && !apb_req.pwrite) ? rd_data : 32'h0000_0000;
            pslverr <= setup_ph & ~mapped;
        end
    end

    // commands and handshakes toward the sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_cmd <= '0;
        end else begin
            seq_cmd.erase_page    <= accept & cmd_erase;
            seq_cmd.write_trigger <= accept & ~cmd_erase & cmd_wtrig;
            seq_cmd.single_write  <= accept & ~cmd_erase & ~cmd_wtrig & cmd_single;
            seq_cmd.release_flash <= timeout_hit;
            seq_cmd.word_valid    <= wdata_wr | (seq_cmd.word_valid & ~seq_evt.word_taken);
            seq_cmd.perf_run      <= perf_start | (seq_cmd.perf_run & ~seq_evt.perf_overflow);
        end
    end

    // checks on the flag behaviour
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_busy_drops_cmd: assert property (
        busy && cmd_any |=> !seq_cmd.erase_page && !seq_cmd.write_trigger
                            && !seq_cmd.single_write && (op == $past(op) || $past(end_op)))
        else $error("command accepted while busy");

    chk_ready_drops_write: assert property (
        wdata_wr && !seq_evt.word_taken |=> !write_data_ready_flag && seq_cmd.word_valid)
        else $error("ready flag did not drop on data write");

    chk_ready_rises: assert property (
        seq_evt.word_taken |=> write_data_ready_flag)
        else $error("ready flag did not rise when word taken");

    chk_timeout_ends: assert property (
        timeout_hit |=> write_word_timeout_flag && !busy && seq_cmd.release_flash
                        ##1 !seq_cmd.release_flash)
        else $error("timeout did not end the write");

    chk_timeout_clears: assert property (
        cmd_any && !timeout_hit |=> !write_word_timeout_flag)
        else $error("command did not clear timeout flag");

    chk_abort_sets: assert property (
        abort_hit |=> erase_aborted_flag && op == OP_IDLE)
        else $error("erase abort not flagged");

    chk_pcrun_clears: assert property (
        seq_evt.perf_overflow && !perf_start |=> !perf_counters_running)
        else $error("counters running flag not cleared on overflow");

    chk_locked_sets: assert property (
        locked_hit |=> locked && !busy)
        else $error("locked flag not set");

    chk_invalid_address_flag_sets: assert property (
        seq_evt.addr_invalid |=> invalid_address_flag [*2] or (invalid_address_flag ##1 $past(accept)))
        else $error("invalid address flag not held");

    chk_wdata_discard: assert property (
        wr_acc && hit_wdata && !write_data_ready_flag |=> $stable(flash_write_data_reg))
        else $error("write data taken while not ready");

    chk_status_read_only: assert property (
        wr_acc && hit_status && !seq_evt.word_taken |=>
            write_data_ready_flag == $past(write_data_ready_flag))
        else $error("status write changed a flag");

    chk_apb_answer: assert property (
        setup_ph |=> pready ##1 !pready)
        else $error("apb answer not one access cycle");

    chk_pcrun_sets: assert property (
        perf_start |=> perf_counters_running && seq_cmd.perf_run)
        else $error("counters running flag not set on start");

    chk_unmapped_err: assert property (
        setup_ph && !mapped |=> pready && pslverr)
        else $error("unmapped access not answered with error");

    chk_irq_level: assert property (
        irq == |(irq_flag & irq_mask))
        else $error("interrupt level does not follow flags and mask");

endmodule

// >>> verif/fcs_status_flags_tb.sv
// self-checking bench for the flash controller status flags
`timescale 1ns/1ps

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
    $display("unexpected at %0t got %h exp %h", $time, (got), (exp)); end end

module fcs_status_flags_tb;
    import fcs_pkg::*;

    logic         pclk;
    logic         presetn;
    logic         psel;
    logic         penable;
    fcs_apb_req_s apb_req;
    logic         pready;
    logic [31:0]  prdata;
    logic         pslverr;
    fcs_seq_evt_s seq_evt;
    fcs_seq_cmd_s seq_cmd;
    logic [31:0]  flash_write_data_reg;
    logic         irq;
    int           fail_count;
    int           samples_checked;
    int           n_erase;
    int           n_trig;
    int           n_rel;
    int           n_single;

    // ten cycle word timeout keeps the run short
    fcs_status_flags #(.WORD_TIMEOUT_NS(250)) u_fcs_status_flags (
        .pclk                 (pclk),
        .presetn              (presetn),
        .psel                 (psel),
        .penable              (penable),
        .apb_req              (apb_req),
        .pready               (pready),
        .prdata               (prdata),
        .pslverr              (pslverr),
        .seq_evt              (seq_evt),
        .seq_cmd              (seq_cmd),
        .flash_write_data_reg (flash_write_data_reg),
        .irq                  (irq)
    );

    // clock generation
    always #(CLK_PERIOD_NS / 2.0) pclk = ~pclk;

    // count the one-cycle command pulses sent to the sequencer
    always @(posedge pclk) begin
        if (seq_cmd.erase_page === 1'b1) n_erase++;
        if (seq_cmd.write_trigger === 1'b1) n_trig++;
        if (seq_cmd.release_flash === 1'b1) n_rel++;
        if (seq_cmd.single_write === 1'b1) n_single++;
    end

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        apb_req <= '{paddr: a, pwrite: w, pwdata: d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail_count++;
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, d, r, e);
    endtask

    // read and compare data and error response
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b0, 32'h0000_0000, r, e);
        `CHK(r, exp)
        `CHK(e, exp_err)
    endtask

    // one-cycle sequencer event
    task automatic pulse(input fcs_seq_evt_s v);
        @(posedge pclk);
        seq_evt <= v;
        @(posedge pclk);
        seq_evt <= '0;
    endtask

    // reset value, read-only status, unmapped address
    task automatic s_reset_ro;
        rd_chk(OFF_STATUS, 32'h0000_0008, 1'b0);
        wr(OFF_STATUS, 32'h0000_0000);
        rd_chk(OFF_STATUS, 32'h0000_0008, 1'b0);
        rd_chk(8'h80, 32'h0000_0000, 1'b1);
    endtask

    // write word handshake, discarded word, completion and interrupt
    task automatic s_write;
        wr(OFF_CMD, 32'h0000_0002);
        wr(OFF_WDATA, 32'h1234_5678);
        rd_chk(OFF_STATUS, 32'h0000_0001, 1'b0);
        `CHK(seq_cmd.word_valid, 1'b1)
        wr(OFF_WDATA, 32'hdead_beef);
        `CHK(flash_write_data_reg, 32'h1234_5678)
        `CHK(n_trig, 1)
        pulse('{word_taken: 1'b1, op_done: 1'b1, default: 1'b0});
        rd_chk(OFF_STATUS, 32'h0000_0008, 1'b0);
        rd_chk(OFF_IRQ_FLAG, 32'h0000_0001, 1'b0);
        `CHK(irq, 1'b0)
        wr(OFF_IRQ_MASK, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b1)
        wr(OFF_IRQ_FLAG, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        rd_chk(OFF_IRQ_FLAG, 32'h0000_0000, 1'b0);
    endtask

    // word timeout, then cleared by an erase that is later interrupted
    task automatic s_timeout_erase;
        wr(OFF_CMD, 32'h0000_0002);
        repeat (20) @(posedge pclk);
        rd_chk(OFF_STATUS, 32'h0000_0018, 1'b0);
        `CHK(n_rel, 1)
        wr(OFF_CMD, 32'h0000_0001);
        rd_chk(OFF_STATUS, 32'h0000_0009, 1'b0);
        wr(OFF_CMD, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        `CHK(n_trig, 2)
        pulse('{erase_interrupted: 1'b1, default: 1'b0});
        rd_chk(OFF_STATUS, 32'h0000_0028, 1'b0);
    endtask

    // access constraint abort, invalid address, perf counters
    task automatic s_locked_perf;
        wr(OFF_CMD, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        `CHK(n_erase, 2)
        pulse('{access_denied: 1'b1, default: 1'b0});
        rd_chk(OFF_STATUS, 32'h0000_000a, 1'b0);
        pulse('{addr_invalid: 1'b1, default: 1'b0});
        rd_chk(OFF_STATUS, 32'h0000_000e, 1'b0);
        wr(OFF_CMD, 32'h0000_0008);
        rd_chk(OFF_STATUS, 32'h0000_004e, 1'b0);
        `CHK(seq_cmd.perf_run, 1'b1)
        pulse('{perf_overflow: 1'b1, default: 1'b0});
        rd_chk(OFF_STATUS, 32'h0000_000e, 1'b0);
        `CHK(seq_cmd.perf_run, 1'b0)
        wr(OFF_CMD, 32'h0000_0004);
        repeat (2) @(posedge pclk);
        `CHK(n_single, 1)
        rd_chk(OFF_STATUS, 32'h0000_0009, 1'b0);
        pulse('{op_done: 1'b1, default: 1'b0});
        rd_chk(OFF_STATUS, 32'h0000_0008, 1'b0);
        `CHK(n_rel, 1)
    endtask

    task automatic end_sim;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        pclk            = 1'b0;
        presetn         = 1'b0;
        psel            = 1'b0;
        penable         = 1'b0;
        apb_req         = '0;
        seq_evt         = '0;
        fail_count      = 0;
        samples_checked = 0;
        n_erase         = 0;
        n_trig          = 0;
        n_rel           = 0;
        n_single        = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        s_reset_ro();
        s_write();
        s_timeout_erase();
        s_locked_perf();
        end_sim();
    end

    // watchdog against a hung handshake
    initial begin
        #(CLK_PERIOD_NS * 4000);
        fail_count++;
        end_sim();
    end
endmodule
